// >>> hdl/hbps_defines.vh
// Constants for the host bridge status and identification register bank
// Functional notes
// - 16-bit status register, resets to 0x0080
// - Bit 15 parity detected reads zero
// - Bit 14 sets when system error sent
// - Only received target abort triggers system error
// - Bit 14 cleared by writing one
// - Bit 13 sets on master abort completion
// - Bit 12 sets on target abort completion
// - Bits 13 and 12 clear only by one
// - Bit 11 target abort signalled reads zero
// - Bits 10:9 select timing read 00
// - Bit 8 data parity reads zero
// - Bit 7 reads one, back-to-back capable
// - Bit 4 reads zero, no capability list
// - Read-only 8-bit revision number register
// - Subclass code reads 00h, host bridge
// - Base class code reads 06h, bridge
// - System error messages only while enable set
`ifndef HBPS_DEFINES_VH
`define HBPS_DEFINES_VH

// Register indices; byte address is four times the index
`define HBPS_IDX_CMD        8'h04
`define HBPS_IDX_STATUS     8'h06
`define HBPS_IDX_REVISION   8'h08
`define HBPS_IDX_SUBCLASS   8'h0A
`define HBPS_IDX_BASECLASS  8'h0B
`define HBPS_IDX_IRQ_STATUS 8'h40
`define HBPS_IDX_IRQ_MASK   8'h41

// Status register field positions
`define HBPS_ST_SYS_ERR     14
`define HBPS_ST_MABORT      13
`define HBPS_ST_TABORT      12

// Command register field position
`define HBPS_CMD_SERR_EN    8

// Reset and fixed values
`define HBPS_STATUS_RESET   16'h0080
`define HBPS_STATUS_FIXED   16'h0080
`define HBPS_SUBCLASS_VAL   8'h00
`define HBPS_BASECLASS_VAL  8'h06

// Interrupt status bit positions
`define HBPS_IRQ_MABORT     0
`define HBPS_IRQ_TABORT     1
`define HBPS_IRQ_SYS_ERR    2
`define HBPS_IRQ_WIDTH      3

// Bus responses
`define HBPS_RESP_OKAY      2'h0
`define HBPS_RESP_SLVERR    2'h2

`endif

// >>> hdl/hbps_top.v
// Host bridge status and identification register bank, AXI4-Lite slave
`timescale 1ns/1ps
`include "hbps_defines.vh"

module hbps_top #(
  parameter ADDR_WIDTH  = 12,
  parameter [7:0] REVISION = 8'h01  // Arbitrary value
) (
  input  wire                  aclk,
  input  wire                  aresetn,
  input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire [2:0]            s_axi_awprot,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire [2:0]            s_axi_arprot,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  input  wire                  hub_master_abort,
  input  wire                  hub_target_abort,
  output reg                   hub_system_error_msg,
  output wire                  irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register selection codes

  localparam [2:0] SEL_NONE      = 3'h0;
  localparam [2:0] SEL_CMD       = 3'h1;
  localparam [2:0] SEL_STATUS    = 3'h2;
  localparam [2:0] SEL_REVISION  = 3'h3;
  localparam [2:0] SEL_SUBCLASS  = 3'h4;
  localparam [2:0] SEL_BASECLASS = 3'h5;
  localparam [2:0] SEL_IRQ_STAT  = 3'h6;
  localparam [2:0] SEL_IRQ_MASK  = 3'h7;

  // Decode a byte address into a register selection
  function [2:0] decode_sel;
    input [ADDR_WIDTH-1:0] addr;
    begin
      decode_sel = SEL_NONE;
      // Only aligned words inside the index range are mapped
      if (addr[1:0] == 2'h0 && addr[ADDR_WIDTH-1:10] == 0) begin
        case (addr[9:2])
          `HBPS_IDX_CMD:        decode_sel = SEL_CMD;
          `HBPS_IDX_STATUS:     decode_sel = SEL_STATUS;
          `HBPS_IDX_REVISION:   decode_sel = SEL_REVISION;
          `HBPS_IDX_SUBCLASS:   decode_sel = SEL_SUBCLASS;
          `HBPS_IDX_BASECLASS:  decode_sel = SEL_BASECLASS;
          `HBPS_IDX_IRQ_STATUS: decode_sel = SEL_IRQ_STAT;
          `HBPS_IDX_IRQ_MASK:   decode_sel = SEL_IRQ_MASK;
          default:              decode_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  reg                    aw_held;      // Write address captured
  reg  [ADDR_WIDTH-1:0]  aw_addr;      // Captured write address
  reg                    w_held;       // Write data captured
  reg  [31:0]            w_data;       // Captured write data
  reg  [3:0]             w_strb;       // Captured byte strobes

  reg                    serr_enable;  // System error message enable
  reg                    flag_sys_err; // Status bit 14
  reg                    flag_mabort;  // Status bit 13
  reg                    flag_tabort;  // Status bit 12
  reg  [`HBPS_IRQ_WIDTH-1:0] irq_status; // Sticky interrupt events
  reg  [`HBPS_IRQ_WIDTH-1:0] irq_mask;   // Interrupt enables

  wire [2:0]             wr_sel;       // Selected register for write
  wire                   wr_fire;      // Write performed this cycle
  wire [2:0]             rd_sel;       // Selected register for read
  wire                   rd_fire;      // Read accepted this cycle
  wire                   send_serr;    // System error event this cycle
  wire [15:0]            status_word;  // Assembled status register
  wire                   clr_sys_err;  // Write-one clear of bit 14
  wire                   clr_mabort;   // Write-one clear of bit 13
  wire                   clr_tabort;   // Write-one clear of bit 12
  wire [`HBPS_IRQ_WIDTH-1:0] irq_events; // Events feeding interrupts
  wire [`HBPS_IRQ_WIDTH-1:0] irq_clear;  // Write-one clears of events

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes

  // Channels are open while nothing is captured and no answer waits
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Write goes ahead once both halves are held
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_sel  = decode_sel(aw_addr);
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_sel  = decode_sel(s_axi_araddr);

  // Capture write address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= {ADDR_WIDTH{1'b0}};
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      // Address channel
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      // Data channel
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped addresses
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HBPS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == SEL_NONE) ? `HBPS_RESP_SLVERR : `HBPS_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command register: only the system error enable is kept

  always @(posedge aclk) begin
    if (!aresetn) begin
      serr_enable <= 1'b0;
    end else if (wr_fire && wr_sel == SEL_CMD && w_strb[1]) begin
      serr_enable <= w_data[`HBPS_CMD_SERR_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flags

  // Message goes out only for target abort, and only when enabled
  assign send_serr = hub_target_abort & serr_enable;

  // Message toward the hub, send_serr registered one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      hub_system_error_msg <= 1'b0;
    end else begin
      hub_system_error_msg <= send_serr;
    end
  end

  // Clears need the upper byte lane and a one in the bit
  assign clr_sys_err = wr_fire & (wr_sel == SEL_STATUS) & w_strb[1]
                       & w_data[`HBPS_ST_SYS_ERR];
  assign clr_mabort  = wr_fire & (wr_sel == SEL_STATUS) & w_strb[1]
                       & w_data[`HBPS_ST_MABORT];
  assign clr_tabort  = wr_fire & (wr_sel == SEL_STATUS) & w_strb[1]
                       & w_data[`HBPS_ST_TABORT];

  // Sticky flags; a new event wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_sys_err <= 1'b0;
      flag_mabort  <= 1'b0;
      flag_tabort  <= 1'b0;
    end else begin
      flag_sys_err <= (flag_sys_err & ~clr_sys_err) | send_serr;
      flag_mabort  <= (flag_mabort & ~clr_mabort) | hub_master_abort;
      flag_tabort  <= (flag_tabort & ~clr_tabort) | hub_target_abort;
    end
  end

  // Fixed bits come from a constant; only 14:12 are live
  assign status_word = `HBPS_STATUS_FIXED
                     | {1'b0, flag_sys_err, flag_mabort, flag_tabort, 12'h000};

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Same events that set the status flags
  assign irq_events = {send_serr, hub_target_abort, hub_master_abort};
  assign irq_clear  = (wr_fire && wr_sel == SEL_IRQ_STAT && w_strb[0])
                      ? w_data[`HBPS_IRQ_WIDTH-1:0] : {`HBPS_IRQ_WIDTH{1'b0}};

  // Sticky status with write-one clear, set wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= {`HBPS_IRQ_WIDTH{1'b0}};
      irq_mask   <= {`HBPS_IRQ_WIDTH{1'b0}};
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      if (wr_fire && wr_sel == SEL_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[`HBPS_IRQ_WIDTH-1:0];
      end
    end
  end

  // Level output while any enabled event is pending
  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Data registered on acceptance, held until taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `HBPS_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `HBPS_RESP_OKAY;
      case (rd_sel)
        SEL_CMD:       s_axi_rdata <= {23'h000000, serr_enable, 8'h00};
        SEL_STATUS:    s_axi_rdata <= {16'h0000, status_word};
        SEL_REVISION:  s_axi_rdata <= {24'h000000, REVISION};
        SEL_SUBCLASS:  s_axi_rdata <= {24'h000000, `HBPS_SUBCLASS_VAL};
        SEL_BASECLASS: s_axi_rdata <= {24'h000000, `HBPS_BASECLASS_VAL};
        SEL_IRQ_STAT:  s_axi_rdata <= {29'h00000000, irq_status};
        SEL_IRQ_MASK:  s_axi_rdata <= {29'h00000000, irq_mask};
        default: begin
          // Unmapped: zero data, slave error
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `HBPS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> dv/hbps_monitor.sv
// Checker of the bank's bus and hub ports
`timescale 1ns/1ps
module hbps_monitor #(parameter ADDR_WIDTH = 12) (
  input wire                  aclk,
  input wire                  aresetn,
  input wire                  s_axi_bvalid,
  input wire                  s_axi_bready,
  input wire [1:0]            s_axi_bresp,
  input wire                  s_axi_arvalid,
  input wire                  s_axi_arready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire                  s_axi_rvalid,
  input wire                  s_axi_rready,
  input wire [31:0]           s_axi_rdata,
  input wire [1:0]            s_axi_rresp,
  input wire                  hub_target_abort,
  input wire                  hub_system_error_msg,
  input wire                  irq
);
  reg [ADDR_WIDTH-1:0] last_ar; // Address of the read under way
  ////////////////////////////////////////////////////////////
  // Remember the accepted read address
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) last_ar <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_arready_rule: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_status_fixed: assert property (
    s_axi_rvalid && last_ar == 12'h018 |-> (s_axi_rdata & 32'hFFFF8FFF) == 32'h80)
    else $error("status fixed bits wrong");
  chk_subclass_val: assert property (
    s_axi_rvalid && last_ar == 12'h028 |-> s_axi_rdata == 32'h0) else $error("subclass");
  chk_base_class: assert property (
    s_axi_rvalid && last_ar == 12'h02C |-> s_axi_rdata == 32'h6) else $error("base class");
  chk_msg_cause: assert property (
    hub_system_error_msg |-> $past(hub_target_abort)) else $error("message without cause");
  chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0) else $error("unmapped read data");
  cover property (hub_system_error_msg);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (irq);
endmodule
bind hbps_top hbps_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) i_mon (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .hub_target_abort, .hub_system_error_msg, .irq);

// >>> dv/hbps_hub_model.sv
// Hub side model: reports completions, counts error messages
`timescale 1ns/1ps
module hbps_hub_model (
  input  wire  aclk,
  input  wire  aresetn,
  input  wire  hub_system_error_msg,
  output logic hub_master_abort,
  output logic hub_target_abort
);
  integer n_msg = 0; // Message pulses seen
  initial hub_master_abort = 1'b0;
  initial hub_target_abort = 1'b0;
  // Count message pulses
  always @(posedge aclk) if (aresetn && hub_system_error_msg) n_msg <= n_msg + 1;
  // One completion after a wait, held one cycle
  task automatic report(input logic ma, input logic ta, input int gap);
    repeat (gap + 1) @(posedge aclk);
    hub_master_abort <= ma;
    hub_target_abort <= ta;
    @(posedge aclk);
    hub_master_abort <= 1'b0;
    hub_target_abort <= 1'b0;
  endtask
endmodule

// >>> dv/test_host_bridge_pci_status_ids.sv
// Self-checking bench of the status and identification bank
`timescale 1ns/1ps
module test_host_bridge_pci_status_ids;
  localparam [7:0] REV = 8'h5A; // Arbitrary revision value
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic        ma, ta, msg, irq;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got, r, seed = 26;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, gr;
  integer      n_mismatch = 0, total_checks = 0, cyc = 0;
  integer      st = 32'h80, irs = 0, msk = 0, en = 0, nmsg = 0;
  logic [11:0] ra [4] = '{12'h018, 12'h020, 12'h028, 12'h02C}; // Fixed registers
  logic [31:0] re [4] = '{32'h80, REV, 32'h0, 32'h6};
  hbps_top #(.ADDR_WIDTH(12), .REVISION(REV)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hub_master_abort(ma),
    .hub_target_abort(ta), .hub_system_error_msg(msg), .irq(irq));
  hbps_hub_model i_hub (.aclk(aclk), .aresetn(aresetn), .hub_system_error_msg(msg),
    .hub_master_abort(ma), .hub_target_abort(ta));
  always #4 aclk = ~aclk;
  ////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected write answer: mapped words OKAY, anything else slave error
  function automatic logic [1:0] wexp(input logic [11:0] a);
    return (a inside {12'h010, 12'h018, 12'h020, 12'h028, 12'h02C, 12'h100, 12'h104})
           ? 2'h0 : 2'h2;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Bus cycles
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic da;
    logic dw;
    da = 0;
    dw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(da && dw)) begin
      @(negedge aclk);
      da = da | (awvalid & awready);
      dw = dw | (wvalid & wready);
      @(posedge aclk);
      if (da) awvalid <= 0;
      if (dw) wvalid <= 0;
    end
    do @(negedge aclk); while (!bvalid);
    gr = bresp;
    @(posedge aclk);
    bready <= 0;
    check(gr, wexp(a));
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 0;
    do @(negedge aclk); while (!rvalid);
    got = rdata;
    gr = rresp;
    @(posedge aclk);
    rready <= 0;
    check(got, exp);
    check(gr, er);
  endtask
  // Hub event with model update
  task automatic ev(input logic m, input logic t);
    i_hub.report(m, t, xs() % 4);
    st = st | (m << 13) | (t << 12) | ((t & en) << 14);
    irs = irs | m | (t << 1) | ((t & en) << 2);
    nmsg = nmsg + (t & en);
    repeat (2) @(posedge aclk);
    check(i_hub.n_msg, nmsg);
  endtask
  // Status write with clear-by-one model
  task automatic wst(input logic [31:0] d);
    wr(12'h018, d, 4'hF);
    st = st & ~(d & 32'h7000);
    rdc(12'h018, st, 2'h0);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 4; i++) begin
      rdc(ra[i], re[i], 2'h0);
      wr(ra[i], 32'hFFFF8FFF, 4'hF);
      rdc(ra[i], re[i], 2'h0);
    end
    rdc(12'h01C, 32'h0, 2'h2);
    wr(12'h01C, 32'hFFFFFFFF, 4'hF);
    ev(0, 1);
    rdc(12'h018, st, 2'h0);
    wr(12'h010, 32'h100, 4'h2);
    en = 1;
    rdc(12'h010, 32'h100, 2'h0);
    wr(12'h104, 32'h7, 4'h1);
    msk = 7;
    rdc(12'h104, 32'h7, 2'h0);
    ev(0, 1);
    ev(1, 0);
    rdc(12'h018, st, 2'h0);
    check(irq, |(irs & msk));
    wst(32'h0);
    wst(32'h2000);
    for (int k = 0; k < 40; k++) begin
      r = xs();
      case (r[1:0])
        2'h0: ev(r[2], r[3]);
        2'h1: wst(xs());
        2'h2: begin
          wr(12'h100, r >> 4, 4'h1);
          irs = irs & ~(r >> 4);
        end
        default: begin
          wr(12'h010, r, 4'h2);
          wr(12'h104, r >> 4, 4'h1);
          en = r[8];
          msk = (r >> 4) & 7;
        end
      endcase
      rdc(12'h018, st, 2'h0);
      rdc(12'h100, irs & 7, 2'h0);
      check(irq, |(irs & msk));
    end
    give_verdict;
  end
endmodule
